// File: design/palette_host_access_port.sv
// Host access logic of the palette converter: pointer, holding, stores
// Overview of operation
// - Select lines decode into eight targets
// - Eight-bit pointer addresses palette and overlay
// - Entries move as red, green, blue cycles
// - Blue write stores palette word, pointer advances
// - Palette read pointer load prefetches, then advances
// - Each blue palette read prefetches next entry
// - Blue write stores overlay word, pointer advances
// - Overlay read pointer load prefetches, then advances
// - Each blue overlay read prefetches next entry
// - Pointer wraps from 255 to zero
// - Overlay uses only low four pointer bits
// - Host bus asynchronous; moves synchronised between accesses
// - Video colour holds during palette transfers only
// - Two hidden bits count phases modulo three
// - Pointer write clears phase; pointer read does not
// - Only eight index bits visible to host
// - Pointer read changes nothing
// - Feature select low disables command register
// - Six-bit depth ignores and zeroes top bits
// - Read mask accessible at any time
`timescale 1ns/100ps
`default_nettype none
module palette_host_access_port (
    // Clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RESET_IN,
    // Host bus
    input wire logic HOST_RD_N_IN,
    input wire logic HOST_WR_N_IN,
    input wire logic [2:0] REG_SELECT_IN,
    input wire logic [palette_port_pkg::COMP_W-1:0] DATA_IN,
    output logic [palette_port_pkg::COMP_W-1:0] DATA_OUT,
    output logic DATA_OE_OUT,
    // Strap
    input wire logic FEATURE_SELECT_IN,
    // Pixel lookup
    input wire logic [palette_port_pkg::PAL_AW-1:0] PIXEL_INDEX_IN,
    output logic [palette_port_pkg::ENTRY_W-1:0] COLOUR_OUT
);
    import palette_port_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        mode_type mode;
        fsm_type fsm;
        logic [7:0] ptr;
        logic [1:0] phase;
        logic [COMP_W-1:0] red;
        logic [COMP_W-1:0] grn;
        logic [COMP_W-1:0] blu;
        logic [COMP_W-1:0] mask;
        logic [COMP_W-1:0] command;
        logic [COMP_W-1:0] dout;
        logic oe;
        logic rd_prev;
        logic wr_prev;
        logic [7:0] xfer_addr;
        logic xfer_ovl;
        logic pix_valid;
        logic [ENTRY_W-1:0] colour;
    } state_type;

    state_type st_reg;
    state_type st_next;

    logic [SYNC_W-1:0] sync_level;
    logic feature;
    logic rd_n_s;
    logic wr_n_s;
    logic [2:0] rs;
    logic [COMP_W-1:0] din;
    logic rd_end;
    logic wr_end;
    logic wide;
    logic host_pal;
    logic is_ptr;
    logic is_data;
    logic [COMP_W-1:0] comp_sel;
    logic [COMP_W-1:0] read_value;

    entry_port_if #(.AW(PAL_AW), .W(ENTRY_W)) pal_if ();
    entry_port_if #(.AW(OVL_AW), .W(ENTRY_W)) ovl_if ();

    // ****************************************************************
    // Host pin crossing
    // ****************************************************************
    // asynchronous host pins
    pin_sync3 #(.W(SYNC_W), .RESET_VAL(SYNC_RESET)) u_sync (
        .clk_in(CORE_CLK_IN),
        .reset_in(RESET_IN),
        .pin_in({FEATURE_SELECT_IN, HOST_RD_N_IN, HOST_WR_N_IN,
            REG_SELECT_IN, DATA_IN}),
        .level_out(sync_level)
    );

    // Select and data lag the strobes equally, so they are valid at ends
    assign {feature, rd_n_s, wr_n_s, rs, din} = sync_level;
    assign rd_end = rd_n_s && !st_reg.rd_prev;
    assign wr_end = wr_n_s && !st_reg.wr_prev;

    // command register only with feature select high
    assign wide = feature && st_reg.command[CMD_WIDE_BIT];

    // ****************************************************************
    // Entry stores
    // ****************************************************************
    entry_store #(.DEPTH(PAL_DEPTH), .AW(PAL_AW), .W(ENTRY_W)) u_pal (
        .clk_in(CORE_CLK_IN),
        .port(pal_if.store)
    );

    entry_store #(.DEPTH(OVL_DEPTH), .AW(OVL_AW), .W(ENTRY_W)) u_ovl (
        .clk_in(CORE_CLK_IN),
        .port(ovl_if.store)
    );

    // Palette host moves take the palette port; pixels get all other cycles
    assign host_pal = !st_reg.xfer_ovl &&
        (st_reg.fsm == FSM_FETCH || st_reg.fsm == FSM_WRITE);
    assign pal_if.we = !st_reg.xfer_ovl && st_reg.fsm == FSM_WRITE;
    assign pal_if.addr = host_pal ? st_reg.xfer_addr : PIXEL_INDEX_IN;
    assign pal_if.wdata = {st_reg.red, st_reg.grn, st_reg.blu};

    // overlay entries use the low four pointer bits
    assign ovl_if.we = st_reg.xfer_ovl && st_reg.fsm == FSM_WRITE;
    assign ovl_if.addr = st_reg.xfer_addr[OVL_AW-1:0];
    assign ovl_if.wdata = {st_reg.red, st_reg.grn, st_reg.blu};

    // ****************************************************************
    // Read data selection
    // ****************************************************************
    // eight target decode
    assign is_ptr = rs == RS_PTR_PAL_WR || rs == RS_PTR_PAL_RD ||
        rs == RS_PTR_OVL_WR || rs == RS_PTR_OVL_RD;
    assign is_data = rs == RS_PAL_DATA || rs == RS_OVL_DATA;

    // component picked by the phase count
    always_comb begin
        unique case (st_reg.phase)
            PHASE_GREEN: comp_sel = st_reg.grn;
            PHASE_BLUE: comp_sel = st_reg.blu;
            default: comp_sel = st_reg.red;
        endcase
    end

    // phase bits never reach the bus
    always_comb begin
        if (is_ptr) begin
            read_value = st_reg.ptr;
        end else if (is_data) begin
            // six-bit reads return zero top bits
            read_value = narrow(comp_sel, wide);
        end else if (rs == RS_READ_MASK) begin
            read_value = st_reg.mask;
        end else begin
            read_value = feature ? st_reg.command : ZERO_BYTE;
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_next = st_reg;
        st_next.rd_prev = rd_n_s;
        st_next.wr_prev = wr_n_s;
        st_next.oe = !rd_n_s;
        if (!rd_n_s) begin
            st_next.dout = read_value;
        end
        // colour only refreshes from a pixel lookup
        st_next.pix_valid = !host_pal;
        if (st_reg.pix_valid) begin
            st_next.colour = pal_if.rdata;
        end

        // Transfer sequencer between stores and holding registers
        unique case (st_reg.fsm)
            FSM_IDLE: st_next.fsm = FSM_IDLE;
            FSM_FETCH: st_next.fsm = FSM_LOAD;
            FSM_LOAD: begin
                {st_next.red, st_next.grn, st_next.blu} =
                    st_reg.xfer_ovl ? ovl_if.rdata : pal_if.rdata;
                st_next.fsm = FSM_IDLE;
            end
            FSM_WRITE: st_next.fsm = FSM_IDLE;
        endcase

        // Host write cycle ends
        if (wr_end) begin
            if (is_ptr) begin
                st_next.ptr = din;
                st_next.phase = PHASE_RED;
                st_next.xfer_addr = din;
                st_next.xfer_ovl = rs == RS_PTR_OVL_WR ||
                    rs == RS_PTR_OVL_RD;
                unique case (rs)
                    RS_PTR_PAL_WR: st_next.mode = MODE_PAL_WR;
                    RS_PTR_OVL_WR: st_next.mode = MODE_OVL_WR;
                    RS_PTR_PAL_RD: st_next.mode = MODE_PAL_RD;
                    default: st_next.mode = MODE_OVL_RD;
                endcase
                if (rs == RS_PTR_PAL_RD || rs == RS_PTR_OVL_RD) begin
                    st_next.fsm = FSM_FETCH;
                    st_next.ptr = din + PTR_STEP;
                end
            end else if (is_data) begin
                unique case (st_reg.phase)
                    PHASE_GREEN: st_next.grn = narrow(din, wide);
                    PHASE_BLUE: st_next.blu = narrow(din, wide);
                    default: st_next.red = narrow(din, wide);
                endcase
                if (st_reg.phase == PHASE_BLUE) begin
                    st_next.fsm = FSM_WRITE;
                    st_next.xfer_addr = st_reg.ptr;
                    st_next.xfer_ovl = rs == RS_OVL_DATA;
                    st_next.ptr = st_reg.ptr + PTR_STEP;
                    st_next.phase = PHASE_RED;
                end else begin
                    st_next.phase = st_reg.phase + PHASE_STEP;
                end
            end else if (rs == RS_READ_MASK) begin
                st_next.mask = din;
            end else if (feature) begin
                st_next.command = din;
            end
        end

        // Host read cycle ends; pointer reads leave all alone
        if (rd_end && is_data) begin
            if (st_reg.phase == PHASE_BLUE) begin
                st_next.fsm = FSM_FETCH;
                st_next.xfer_addr = st_reg.ptr;
                st_next.xfer_ovl = rs == RS_OVL_DATA;
                st_next.ptr = st_reg.ptr + PTR_STEP;
                st_next.phase = PHASE_RED;
            end else begin
                st_next.phase = st_reg.phase + PHASE_STEP;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // everything here counts on the running pixel clock
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            st_reg <= '{
                mode: MODE_PAL_WR,
                fsm: FSM_IDLE,
                ptr: ZERO_BYTE,
                phase: PHASE_RED,
                red: ZERO_BYTE,
                grn: ZERO_BYTE,
                blu: ZERO_BYTE,
                mask: ZERO_BYTE,
                command: ZERO_BYTE,
                dout: ZERO_BYTE,
                oe: 1'b0,
                rd_prev: 1'b1,
                wr_prev: 1'b1,
                xfer_addr: ZERO_BYTE,
                xfer_ovl: 1'b0,
                pix_valid: 1'b0,
                colour: ZERO_ENTRY
            };
        end else begin
            st_reg <= st_next;
        end
    end

    assign DATA_OUT = st_reg.dout;
    assign DATA_OE_OUT = st_reg.oe;
    assign COLOUR_OUT = st_reg.colour;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (RESET_IN);

    chk_ptr_load_clear: assert property (
        wr_end && is_ptr |=> st_reg.phase == PHASE_RED &&
            st_reg.xfer_addr == $past(din))
        else $error("pointer write left phase set");

    chk_ptr_read_quiet: assert property (
        rd_end && is_ptr |=> $stable(st_reg.ptr) &&
            $stable(st_reg.phase) && $stable(st_reg.mode))
        else $error("pointer read disturbed state");

    chk_phase_range: assert property (
        st_reg.phase != 2'h3)
        else $error("phase count left modulo three");

    chk_blue_store: assert property (
        wr_end && rs == RS_PAL_DATA && st_reg.phase == PHASE_BLUE
        |=> pal_if.we && pal_if.addr == $past(st_reg.ptr) &&
            st_reg.ptr == $past(st_reg.ptr) + PTR_STEP)
        else $error("blue write did not store and advance");

    chk_rg_latch_only: assert property (
        wr_end && is_data && st_reg.phase != PHASE_BLUE
        |=> !pal_if.we && !ovl_if.we)
        else $error("store written before blue");

    chk_ptr_wrap: assert property (
        (wr_end || rd_end) && rs == RS_PAL_DATA &&
        st_reg.phase == PHASE_BLUE && st_reg.ptr == PTR_LAST
        |=> st_reg.ptr == ZERO_BYTE)
        else $error("pointer did not wrap");

    chk_read_prefetch: assert property (
        wr_end && rs == RS_PTR_PAL_RD && st_reg.fsm == FSM_IDLE
        |=> st_reg.fsm == FSM_FETCH ##2
            {st_reg.red, st_reg.grn, st_reg.blu} == $past(pal_if.rdata))
        else $error("read pointer load did not prefetch");

    chk_colour_hold: assert property (
        host_pal |-> ##2 $stable(st_reg.colour))
        else $error("colour changed during host transfer");

    chk_six_bit_read: assert property (
        !rd_n_s && is_data && !wide |=> st_reg.dout[7:6] == 2'h0)
        else $error("six-bit read drove top bits");

    chk_ovl_low_bits: assert property (
        wr_end && rs == RS_OVL_DATA && st_reg.phase == PHASE_BLUE
        |=> ovl_if.we && ovl_if.addr == $past(st_reg.ptr[3:0]))
        else $error("overlay store used wrong address");

    chk_mask_write: assert property (
        wr_end && rs == RS_READ_MASK |=> st_reg.mask == $past(din))
        else $error("mask write lost");

    chk_cmd_off: assert property (
        !feature && wr_end && rs == RS_COMMAND |=> $stable(st_reg.command))
        else $error("command written with feature select low");

    cov_pal_write: cover property (
        wr_end && rs == RS_PAL_DATA && st_reg.phase == PHASE_BLUE);
    cov_pal_prefetch: cover property (
        rd_end && rs == RS_PAL_DATA && st_reg.phase == PHASE_BLUE);
    cov_wrap: cover property (
        wr_end && is_data && st_reg.phase == PHASE_BLUE &&
        st_reg.ptr == PTR_LAST);
    cov_ovl_read: cover property (
        wr_end && rs == RS_PTR_OVL_RD);
endmodule
`default_nettype wire

// File: design/palette_port_pkg.sv
// Shared constants, types and helpers of the palette host access port
`default_nettype none
package palette_port_pkg;

    // ****************************************************************
    // Widths and depths
    // ****************************************************************
    localparam int COMP_W = 8;
    localparam int ENTRY_W = 3 * COMP_W;
    localparam int PAL_DEPTH = 256;
    localparam int PAL_AW = 8;
    localparam int OVL_DEPTH = 16;
    localparam int OVL_AW = 4;
    localparam int SYNC_W = 14;

    // ****************************************************************
    // Register select codes
    // ****************************************************************
    localparam logic [2:0] RS_PTR_PAL_WR = 3'h0;
    localparam logic [2:0] RS_PAL_DATA = 3'h1;
    localparam logic [2:0] RS_READ_MASK = 3'h2;
    localparam logic [2:0] RS_PTR_PAL_RD = 3'h3;
    localparam logic [2:0] RS_PTR_OVL_WR = 3'h4;
    localparam logic [2:0] RS_OVL_DATA = 3'h5;
    localparam logic [2:0] RS_COMMAND = 3'h6;
    localparam logic [2:0] RS_PTR_OVL_RD = 3'h7;

    // ****************************************************************
    // Component phase, field positions and reset values
    // ****************************************************************
    localparam logic [1:0] PHASE_RED = 2'h0;
    localparam logic [1:0] PHASE_GREEN = 2'h1;
    localparam logic [1:0] PHASE_BLUE = 2'h2;
    localparam logic [1:0] PHASE_STEP = 2'h1;
    localparam logic [7:0] PTR_STEP = 8'h01;
    localparam logic [7:0] PTR_LAST = 8'hFF;
    localparam int CMD_WIDE_BIT = 1;
    localparam logic [COMP_W-1:0] SIX_BIT_MASK = 8'h3F;
    localparam logic [COMP_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [ENTRY_W-1:0] ZERO_ENTRY = 24'h00_0000;
    // Strobes idle high, everything else low
    localparam logic [SYNC_W-1:0] SYNC_RESET = 14'h1800;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        MODE_PAL_WR = 4'b0001,
        MODE_PAL_RD = 4'b0010,
        MODE_OVL_WR = 4'b0100,
        MODE_OVL_RD = 4'b1000
    } mode_type;

    typedef enum logic [3:0] {
        FSM_IDLE = 4'b0001,
        FSM_FETCH = 4'b0010,
        FSM_LOAD = 4'b0100,
        FSM_WRITE = 4'b1000
    } fsm_type;

    // Six-bit depth drops the two top bits of a component
    function automatic logic [COMP_W-1:0] narrow(
        input logic [COMP_W-1:0] value,
        input logic wide
    );
        narrow = wide ? value : (value & SIX_BIT_MASK);
    endfunction

endpackage
`default_nettype wire

// File: design/entry_port_if.sv
// Port bundle between the access logic and one entry store
`timescale 1ns/100ps
`default_nettype none
interface entry_port_if #(
    parameter int AW = 8,
    parameter int W = 24
) ();
    logic we;
    logic [AW-1:0] addr;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;

    modport ctrl (output we, output addr, output wdata, input rdata);
    modport store (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// File: design/entry_store.sv
// Single-port entry memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module entry_store #(
    parameter int DEPTH = 256,
    parameter int AW = 8,
    parameter int W = 24
) (
    // Clock
    input wire logic clk_in,
    // Access port
    entry_port_if.store port
);
    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] rdata_reg;

    if (DEPTH > (1 << AW) || DEPTH < 2) begin : g_depth_check
        $error("entry_store depth does not fit the address width");
    end

    // Read before write, read data always one cycle after the address
    always_ff @(posedge clk_in) begin
        if (port.we) begin
            mem[port.addr] <= port.wdata;
        end
        rdata_reg <= mem[port.addr];
    end

    assign port.rdata = rdata_reg;
endmodule
`default_nettype wire

// File: design/pin_sync3.sv
// Three-stage pin synchroniser that accepts agreeing late stages only
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 #(
    parameter int W = 14,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Pins and settled levels
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_type;

    sync_state_type st_reg;
    sync_state_type st_next;

    // A bit only moves once stages two and three agree on it
    always_comb begin
        st_next = st_reg;
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < W; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
    end

    // State register
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_reg <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.q;
endmodule
`default_nettype wire

// File: verification/host_bus_model.sv
// Host processor model issuing strobed accesses on the parallel bus
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
    // Clock
    input wire logic clk_in,
    // Bus towards the device
    output logic rd_n_out,
    output logic wr_n_out,
    output logic [2:0] sel_out,
    output logic [7:0] data_out,
    input wire logic [7:0] data_in,
    input wire logic oe_in
);
    // Idle bus: strobes high
    initial begin
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        sel_out = 3'h0;
        data_out = 8'h00;
    end

    // one select and one component per strobe
    task automatic wr(input logic [2:0] sel, input logic [7:0] val);
        @(posedge clk_in);
        sel_out <= sel;
        data_out <= val;
        wr_n_out <= 1'b0;
        repeat (6) @(posedge clk_in);
        wr_n_out <= 1'b1;
        // Hold past the synced strobe end, then scramble the bus
        repeat (5) @(posedge clk_in);
        data_out <= ~val;
        repeat (7) @(posedge clk_in);
    endtask

    // reads spaced like writes, data taken while driven
    task automatic rd(input logic [2:0] sel, output logic [7:0] val);
        @(posedge clk_in);
        sel_out <= sel;
        rd_n_out <= 1'b0;
        repeat (8) @(posedge clk_in);
        val = (oe_in === 1'b1) ? data_in : 8'hxx;
        rd_n_out <= 1'b1;
        repeat (12) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// File: verification/tb_palette_host_access_port.sv
// Self-checking bench of the palette host access port
`timescale 1ns/100ps
`default_nettype none
module tb_palette_host_access_port;
    import palette_port_pkg::*;
    logic clk;
    logic rst;
    logic fsel;
    logic [7:0] pix;
    logic rd_n;
    logic wr_n;
    logic [2:0] sel;
    logic [7:0] hdata;
    logic [7:0] ddata;
    logic oe;
    logic [23:0] colour;
    int fail_count = 0;
    int n_tests = 0;

    palette_host_access_port uut (
        .CORE_CLK_IN(clk), .RESET_IN(rst), .HOST_RD_N_IN(rd_n),
        .HOST_WR_N_IN(wr_n), .REG_SELECT_IN(sel), .DATA_IN(hdata),
        .DATA_OUT(ddata), .DATA_OE_OUT(oe), .FEATURE_SELECT_IN(fsel),
        .PIXEL_INDEX_IN(pix), .COLOUR_OUT(colour));
    host_bus_model host (
        .clk_in(clk), .rd_n_out(rd_n), .wr_n_out(wr_n), .sel_out(sel),
        .data_out(hdata), .data_in(ddata), .oe_in(oe));

    // pixel clock runs throughout host traffic
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check24(logic [23:0] exp);
        n_tests++;
        if (colour !== exp) begin
            fail_count++;
            $display("unexpected colour: expected %h seen %h", exp, colour);
        end
    endtask

    task automatic rd_chk(logic [2:0] s, logic [7:0] exp, string what);
        logic [7:0] v;
        host.rd(s, v);
        check8(what, exp, v);
    endtask

    task automatic put(logic [2:0] s, logic [7:0] r, g, b);
        host.wr(s, r);
        host.wr(s, g);
        host.wr(s, b);
    endtask

    // Red, green, blue come back in that order
    task automatic get(logic [2:0] s, logic [7:0] r, g, b);
        rd_chk(s, r, "red");
        rd_chk(s, g, "green");
        rd_chk(s, b, "blue");
    endtask

    // Lookup result is settled a few edges after the index moves
    task automatic look(logic [7:0] idx, logic [23:0] exp);
        @(posedge clk);
        pix <= idx;
        repeat (4) @(posedge clk);
        check24(exp);
    endtask

    // Watchdog: the tests need well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        fsel = 1'b1;
        pix = 8'h00;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_chk(RS_PTR_PAL_WR, 8'h00, "reset pointer");
        $display("test reset done");
        host.wr(RS_COMMAND, 8'h02);
        rd_chk(RS_COMMAND, 8'h02, "command");
        host.wr(RS_PTR_PAL_WR, 8'hFE);
        put(RS_PAL_DATA, 8'hA1, 8'hB2, 8'hC3);
        put(RS_PAL_DATA, 8'hD4, 8'hE5, 8'hF6);
        rd_chk(RS_PTR_PAL_RD, 8'h00, "wrap pointer");
        look(8'hFF, 24'hD4_E5F6);
        host.wr(RS_PTR_PAL_RD, 8'hFE);
        get(RS_PAL_DATA, 8'hA1, 8'hB2, 8'hC3);
        get(RS_PAL_DATA, 8'hD4, 8'hE5, 8'hF6);
        rd_chk(RS_PTR_PAL_WR, 8'h01, "read pointer");
        $display("test palette block done");
        host.wr(RS_PTR_PAL_WR, 8'h10);
        host.wr(RS_PAL_DATA, 8'h11);
        host.wr(RS_PTR_PAL_WR, 8'h10);
        host.wr(RS_PAL_DATA, 8'h22);
        rd_chk(RS_PTR_PAL_WR, 8'h10, "mid pointer");
        host.wr(RS_PAL_DATA, 8'h33);
        rd_chk(RS_PTR_PAL_WR, 8'h10, "green pointer");
        host.wr(RS_PAL_DATA, 8'h44);
        look(8'h10, 24'h22_3344);
        $display("test phase done");
        host.wr(RS_PTR_OVL_WR, 8'h35);
        put(RS_OVL_DATA, 8'h5A, 8'h6B, 8'h7C);
        rd_chk(RS_PTR_OVL_RD, 8'h36, "overlay pointer");
        host.wr(RS_PTR_OVL_RD, 8'hF5);
        get(RS_OVL_DATA, 8'h5A, 8'h6B, 8'h7C);
        rd_chk(RS_PTR_OVL_RD, 8'hF7, "overlay next");
        $display("test overlay done");
        host.wr(RS_READ_MASK, 8'hA5);
        rd_chk(RS_READ_MASK, 8'hA5, "mask");
        // Mid-run reset clears the mask and the pointer
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_chk(RS_READ_MASK, 8'h00, "mask after reset");
        rd_chk(RS_PTR_PAL_WR, 8'h00, "pointer after reset");
        host.wr(RS_COMMAND, 8'h00);
        host.wr(RS_PTR_PAL_WR, 8'h20);
        put(RS_PAL_DATA, 8'hFF, 8'hC1, 8'h80);
        host.wr(RS_PTR_PAL_RD, 8'h20);
        get(RS_PAL_DATA, 8'h3F, 8'h01, 8'h00);
        @(posedge clk);
        fsel <= 1'b0;
        host.wr(RS_COMMAND, 8'h02);
        rd_chk(RS_COMMAND, 8'h00, "command off");
        // The write with the strap low must not have landed
        @(posedge clk);
        fsel <= 1'b1;
        rd_chk(RS_COMMAND, 8'h00, "command kept");
        $display("test depth and strap done");
        stop_test();
    end
endmodule
`default_nettype wire
